// >>> utxeis_regs.svh
// register indices, field positions, reset values and bus codes of the flag block
`ifndef UTXEIS_REGS_SVH
`define UTXEIS_REGS_SVH

// ------------------------------------------------------------
// geometry
// ------------------------------------------------------------
`define UTXEIS_NUM_EP 16
`define UTXEIS_FLAG_W 16
`define UTXEIS_ADDR_W 12
`define UTXEIS_DATA_W 32
`define UTXEIS_STRB_W 4
`define UTXEIS_IDX_W 10
`define UTXEIS_CTRL_EP_BIT 0
`define UTXEIS_MODE_HOST_BIT 0
`define UTXEIS_IDX_LSB 2
`define UTXEIS_LANE0 0
`define UTXEIS_LANE1 1
`define UTXEIS_LANE0_LSB 0
`define UTXEIS_LANE0_MSB 7
`define UTXEIS_LANE1_LSB 8
`define UTXEIS_LANE1_MSB 15

// ------------------------------------------------------------
// register indices, byte address is index times four
// ------------------------------------------------------------
`define UTXEIS_IDX_STATUS 10'h002
`define UTXEIS_IDX_ENABLE 10'h006
`define UTXEIS_IDX_CONFIG 10'h008
`define UTXEIS_IDX_MODE 10'h00A

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define UTXEIS_RST_STATUS 16'h0000
`define UTXEIS_RST_ENABLE 16'hFFFF
`define UTXEIS_RST_CONFIG 16'hFFFF
`define UTXEIS_RST_MODE 1'b0

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define UTXEIS_RESP_OKAY 2'b00
`define UTXEIS_RESP_SLVERR 2'b10
`define UTXEIS_RDATA_ZERO 32'h0000_0000

`endif

// >>> utxeis_pkg.sv
// types shared by the transmit endpoint flag block
`include "utxeis_regs.svh"

package utxeis_pkg;

    // ------------------------------------------------------------
    // endpoint events from the controller core
    // ------------------------------------------------------------
    typedef struct packed {
        logic ctrl_in;
        logic ctrl_out;
        logic [`UTXEIS_NUM_EP-1:1] in_done;
        logic [`UTXEIS_NUM_EP-1:1] out_done;
    } utxeis_events_t;

    // ------------------------------------------------------------
    // captured bus requests
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`UTXEIS_ADDR_W-1:0] addr;
        logic [2:0] prot;
    } utxeis_addr_t;

    typedef struct packed {
        logic [`UTXEIS_DATA_W-1:0] data;
        logic [`UTXEIS_STRB_W-1:0] strb;
    } utxeis_wdata_t;

    typedef struct packed {
        logic status;
        logic enable;
        logic cfg;
        logic mode;
    } utxeis_sel_t;

    // ------------------------------------------------------------
    // channel state machines
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } utxeis_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } utxeis_rd_state_t;

endpackage

// >>> utxeis_flag_bank.sv
// sticky endpoint flags with set-over-clear and configuration gating
`timescale 1ns/1ps
`default_nettype none
`include "utxeis_regs.svh"

module utxeis_flag_bank
    import utxeis_pkg::*;
#(
    parameter int N = `UTXEIS_FLAG_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] set_i,
    input wire logic [N-1:0] clr_i,
    input wire logic [N-1:0] keep_i,
    output logic [N-1:0] flags_q
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (N < 1 || N > `UTXEIS_FLAG_W) begin : g_bad_width
        $error("flag bank width out of range");
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [N-1:0] flags_d;

    // set is or-ed after the clear so an event in the clearing cycle survives
    // an unconfigured endpoint never holds a flag
    assign flags_d = ((flags_q & ~clr_i) | set_i) & keep_i;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= N'(`UTXEIS_RST_STATUS);
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule

`default_nettype wire

// >>> utxeis_top.sv
// transmit endpoint interrupt flags with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
`include "utxeis_regs.svh"

module utxeis_top
    import utxeis_pkg::*;
#(
    parameter int NUM_EP = `UTXEIS_NUM_EP
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`UTXEIS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`UTXEIS_DATA_W-1:0] s_axi_wdata,
    input wire logic [`UTXEIS_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`UTXEIS_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [`UTXEIS_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire utxeis_events_t ep_events,
    output logic host_mode,
    output logic irq
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM_EP != `UTXEIS_NUM_EP) begin : g_bad_ep
        $error("endpoint count must match the status word width");
    end
    // the decoder drops the byte-lane bits, so the index must fill the rest
    if (`UTXEIS_IDX_W != `UTXEIS_ADDR_W - `UTXEIS_IDX_LSB) begin : g_bad_idx
        $error("register index width does not fit the address width");
    end
    // sixteen-bit registers are returned zero-extended in one data word
    if (`UTXEIS_DATA_W < `UTXEIS_FLAG_W) begin : g_bad_data
        $error("data word narrower than the status word");
    end

    localparam int FW = `UTXEIS_FLAG_W;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic utxeis_sel_t decode(input logic [`UTXEIS_ADDR_W-1:0] addr);
        logic [`UTXEIS_IDX_W-1:0] idx;
        utxeis_sel_t sel;
        idx = addr[`UTXEIS_ADDR_W-1:`UTXEIS_IDX_LSB];
        sel.status = (idx == `UTXEIS_IDX_STATUS);
        sel.enable = (idx == `UTXEIS_IDX_ENABLE);
        sel.cfg = (idx == `UTXEIS_IDX_CONFIG);
        sel.mode = (idx == `UTXEIS_IDX_MODE);
        return sel;
    endfunction

    function automatic logic mapped(input utxeis_sel_t sel);
        return sel.status | sel.enable | sel.cfg | sel.mode;
    endfunction

    // one answer code rule for both channels
    function automatic logic [1:0] resp_code(input logic ok);
        return ok ? `UTXEIS_RESP_OKAY : `UTXEIS_RESP_SLVERR;
    endfunction

    // the sending direction of endpoints 1-15 follows the operating mode
    function automatic logic [NUM_EP-1:1] sending(
        input logic host,
        input utxeis_events_t ev
    );
        return host ? ev.out_done : ev.in_done;
    endfunction

    // byte-lane merge of a sixteen-bit register
    function automatic logic [FW-1:0] merge16(
        input logic [FW-1:0] old,
        input logic [`UTXEIS_DATA_W-1:0] data,
        input logic [`UTXEIS_STRB_W-1:0] strb
    );
        logic [FW-1:0] res;
        res = old;
        if (strb[`UTXEIS_LANE0]) begin
            res[`UTXEIS_LANE0_MSB:`UTXEIS_LANE0_LSB] = data[`UTXEIS_LANE0_MSB:`UTXEIS_LANE0_LSB];
        end
        if (strb[`UTXEIS_LANE1]) begin
            res[`UTXEIS_LANE1_MSB:`UTXEIS_LANE1_LSB] = data[`UTXEIS_LANE1_MSB:`UTXEIS_LANE1_LSB];
        end
        return res;
    endfunction

    function automatic logic [`UTXEIS_DATA_W-1:0] widen(input logic [FW-1:0] v);
        return {{(`UTXEIS_DATA_W - FW){1'b0}}, v};
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    utxeis_wr_state_t wr_state_q;
    utxeis_rd_state_t rd_state_q;
    utxeis_addr_t aw_q;
    utxeis_wdata_t w_q;
    logic aw_have_q;
    logic w_have_q;
    logic [1:0] bresp_q;
    logic [`UTXEIS_DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic [FW-1:0] enable_q;
    logic [FW-1:0] config_q;
    logic host_q;
    logic [FW-1:0] flags_q;

    // ------------------------------------------------------------
    // write channel decode
    // ------------------------------------------------------------
    wire logic wr_idle = (wr_state_q == WR_COLLECT);
    wire logic aw_fire = s_axi_awvalid & s_axi_awready;
    wire logic w_fire = s_axi_wvalid & s_axi_wready;
    wire logic b_fire = s_axi_bvalid & s_axi_bready;
    wire logic wr_go = wr_idle & aw_have_q & w_have_q;
    wire utxeis_sel_t wsel = decode(aw_q.addr);
    wire logic wr_ok = mapped(wsel);
    wire logic wr_enable = wr_go & wsel.enable;
    wire logic wr_config = wr_go & wsel.cfg;
    wire logic wr_mode = wr_go & wsel.mode & w_q.strb[`UTXEIS_LANE0];

    assign s_axi_awready = wr_idle & ~aw_have_q;
    assign s_axi_wready = wr_idle & ~w_have_q;
    assign s_axi_bvalid = (wr_state_q == WR_RESP);
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------
    // read channel decode
    // ------------------------------------------------------------
    wire logic rd_idle = (rd_state_q == RD_IDLE);
    wire logic ar_fire = s_axi_arvalid & s_axi_arready;
    wire logic r_fire = s_axi_rvalid & s_axi_rready;
    wire utxeis_sel_t rsel = decode(s_axi_araddr);
    wire logic rd_ok = mapped(rsel);
    wire logic rd_status = ar_fire & rsel.status;

    assign s_axi_arready = rd_idle;
    assign s_axi_rvalid = (rd_state_q == RD_DATA);
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ------------------------------------------------------------
    // read data words
    // ------------------------------------------------------------
    // status is read-only; unused write fields are ignored
    wire logic [FW-1:0] rd_word_status = flags_q;
    wire logic [`UTXEIS_DATA_W-1:0] rd_word_enable = widen(enable_q);
    wire logic [`UTXEIS_DATA_W-1:0] rd_word_config = widen(config_q);
    // only the host bit of the mode word is stored; the rest reads zero
    wire logic [`UTXEIS_DATA_W-1:0] rd_word_mode = widen(FW'(host_q));
    wire logic [`UTXEIS_DATA_W-1:0] rd_mux =
        rsel.status ? widen(rd_word_status) :
        rsel.enable ? rd_word_enable :
        rsel.cfg ? rd_word_config :
        rsel.mode ? rd_word_mode :
        `UTXEIS_RDATA_ZERO;

    // ------------------------------------------------------------
    // event mapping
    // ------------------------------------------------------------
    // the sending direction depends on mode: device sends on IN endpoints,
    // host sends on OUT endpoints, so the same bit changes meaning
    // events are pulses; a held level simply sets its flag again every cycle,
    // so a slow source cannot lose an event to a read
    wire logic [NUM_EP-1:1] send_events =
        sending(host_q, ep_events);
    // one shared flag for both control directions
    wire logic ctrl_event = ep_events.ctrl_in | ep_events.ctrl_out;
    wire logic [FW-1:0] flag_set = {send_events, ctrl_event};

    // a read clears exactly the flags it returned; later events stay
    wire logic [FW-1:0] read_clear = rd_status ? flags_q : {FW{1'b0}};
    // status is read-only: a write is answered but clears nothing, so a flag
    // is only lost by being returned to a read or by clearing its config bit
    wire logic [FW-1:0] flag_clear = read_clear;

    // ------------------------------------------------------------
    // flag storage
    // ------------------------------------------------------------
    utxeis_flag_bank #(
        .N(FW)
    ) u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_i(flag_set),
        .clr_i(flag_clear),
        .keep_i(config_q),
        .flags_q(flags_q)
    );

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    // disabled flags still latch; only the output is gated
    // combinational from registers, so it follows a flag in the same cycle
    wire logic [FW-1:0] irq_pending = flags_q & enable_q;
    assign irq = |irq_pending;
    assign host_mode = host_q;

    // ------------------------------------------------------------
    // write address and data capture, either order
    // ------------------------------------------------------------
    // each half is held until both are in; waiting for both before raising
    // ready would deadlock a master that offers them one at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_q <= '0;
        end else if (aw_fire) begin
            aw_have_q <= 1'b1;
            aw_q <= '{addr: s_axi_awaddr, prot: s_axi_awprot};
        end else if (wr_go) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_q <= '0;
        end else if (w_fire) begin
            w_have_q <= 1'b1;
            w_q <= '{data: s_axi_wdata, strb: s_axi_wstrb};
        end else if (wr_go) begin
            w_have_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write state machine
    // ------------------------------------------------------------
    // bvalid rises at the same edge as the register update, so software never
    // sees an answer before the write has landed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= WR_COLLECT;
            bresp_q <= `UTXEIS_RESP_OKAY;
        end else begin
            case (wr_state_q)
                WR_COLLECT: begin
                    if (wr_go) begin
                        wr_state_q <= WR_RESP;
                        bresp_q <= resp_code(wr_ok);
                    end
                end
                WR_RESP: begin
                    if (b_fire) begin
                        wr_state_q <= WR_COLLECT;
                    end
                end
                default: begin
                    wr_state_q <= WR_COLLECT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // an unmapped address matches none of these, so it changes nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= `UTXEIS_RST_ENABLE;
        end else if (wr_enable) begin
            enable_q <= merge16(enable_q, w_q.data, w_q.strb);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_q <= `UTXEIS_RST_CONFIG;
        end else if (wr_config) begin
            config_q <= merge16(config_q, w_q.data, w_q.strb);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_q <= `UTXEIS_RST_MODE;
        end else if (wr_mode) begin
            host_q <= w_q.data[`UTXEIS_MODE_HOST_BIT];
        end
    end

    // ------------------------------------------------------------
    // read state machine
    // ------------------------------------------------------------
    // rdata is captured at the address edge so the returned word and the
    // clear see the same flag snapshot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= RD_IDLE;
            rdata_q <= `UTXEIS_RDATA_ZERO;
            rresp_q <= `UTXEIS_RESP_OKAY;
        end else begin
            case (rd_state_q)
                RD_IDLE: begin
                    if (ar_fire) begin
                        rd_state_q <= RD_DATA;
                        rdata_q <= rd_mux;
                        rresp_q <= resp_code(rd_ok);
                    end
                end
                RD_DATA: begin
                    if (r_fire) begin
                        rd_state_q <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_q <= RD_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> utxeis_top_sva.sv
// concurrent checks on the ports of the transmit endpoint flag block
`timescale 1ns/1ps
`default_nettype none
`include "utxeis_regs.svh"

module utxeis_top_sva
    import utxeis_pkg::*;
#(
    parameter int NUM_EP = `UTXEIS_NUM_EP
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [`UTXEIS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [`UTXEIS_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire utxeis_events_t ep_events,
    input wire logic host_mode,
    input wire logic irq
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    wire logic [`UTXEIS_IDX_W-1:0] ar_idx = s_axi_araddr[11:2];
    wire logic ar_mapped = (ar_idx == `UTXEIS_IDX_STATUS) || (ar_idx == `UTXEIS_IDX_ENABLE)
        || (ar_idx == `UTXEIS_IDX_CONFIG) || (ar_idx == `UTXEIS_IDX_MODE);
    // an idle write side guarantees no register update at the next edge
    wire logic wr_idle = s_axi_awready && s_axi_wready;
    wire logic [15:1] ep_src = host_mode ? ep_events.out_done : ep_events.in_done;
    wire logic ev_none = !ep_events.ctrl_in && !ep_events.ctrl_out && (ep_src == 15'h0000);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_flags_reset: assert property ($rose(aresetn) |-> !irq && !s_axi_rvalid)
        else $error("irq or rvalid high just after reset");
    a_word_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data wider than sixteen bits");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed before taken");
    a_read_unmapped: assert property (rd_taken ##0 !ar_mapped |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");
    a_flag_sticky: assert property (irq && !s_axi_arvalid && wr_idle |=> irq)
        else $error("pending interrupt dropped without clear");
    a_quiet_no_irq: assert property (!irq && wr_idle && ev_none |=> !irq)
        else $error("interrupt without a sending event");
    c_read_race: cover property (rd_taken ##0 ep_events.in_done[1]);
endmodule

bind utxeis_top utxeis_top_sva #(.NUM_EP(NUM_EP)) u_sva (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ep_events, .host_mode, .irq
);
`default_nettype wire

// >>> tb_usb_tx_endpoint_irq_status.sv
// self-checking bench for the transmit endpoint flag block
`timescale 1ns/1ps
`default_nettype none
`include "utxeis_regs.svh"

module tb_usb_tx_endpoint_irq_status;
    // ------------------------------------------------------------
    // signals and constants
    // ------------------------------------------------------------
    localparam logic [11:0] A_ST = {`UTXEIS_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_EN = {`UTXEIS_IDX_ENABLE, 2'b00};
    localparam logic [11:0] A_CF = {`UTXEIS_IDX_CONFIG, 2'b00};
    localparam logic [11:0] A_MD = {`UTXEIS_IDX_MODE, 2'b00};
    localparam logic [11:0] A_BAD = 12'h100;
    localparam logic [1:0] OK = `UTXEIS_RESP_OKAY;
    localparam logic [1:0] ERR = `UTXEIS_RESP_SLVERR;
    localparam utxeis_pkg::utxeis_events_t E_IN = '{1'b0, 1'b0, 15'h7FFF, 15'h0000};
    localparam utxeis_pkg::utxeis_events_t E_OUT = '{1'b0, 1'b0, 15'h0000, 15'h7FFF};
    localparam utxeis_pkg::utxeis_events_t E_CI = '{1'b1, 1'b0, 15'h0000, 15'h0000};
    localparam utxeis_pkg::utxeis_events_t E_CO = '{1'b0, 1'b1, 15'h0000, 15'h0000};
    localparam utxeis_pkg::utxeis_events_t E_15 = '{1'b0, 1'b0, 15'h4000, 15'h0000};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, host_mode, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    utxeis_pkg::utxeis_events_t ev = '0;
    int err_count = 0;
    int samples_checked = 0;

    always #25 aclk = ~aclk;

    utxeis_top dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ep_events(ev),
        .host_mode(host_mode), .irq(irq)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = OK);
        logic aw_ok;
        logic w_ok;
        logic aw_now;
        logic w_now;
        logic [1:0] got_r;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // ready is judged between edges, where it has settled
        while (!(aw_ok && w_ok)) begin
            @(negedge aclk);
            aw_now = !aw_ok && awready === 1'b1;
            w_now = !w_ok && wready === 1'b1;
            @(posedge aclk);
            if (aw_now) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (w_now) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        got_r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
        check(32'(got_r), 32'(er));
        @(negedge aclk);
    endtask

    // events ride with the read request so they meet the clearing edge
    task automatic rc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = OK,
                      input utxeis_pkg::utxeis_events_t e = '0);
        logic [31:0] got;
        logic [1:0] got_r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ev <= e;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        ev <= '0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        got = rdata;
        got_r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
        check(got, exp);
        check(32'(got_r), 32'(er));
        @(negedge aclk);
    endtask

    task automatic pulse(input utxeis_pkg::utxeis_events_t e);
        @(posedge aclk);
        ev <= e;
        @(posedge aclk);
        ev <= '0;
        @(negedge aclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rc(A_ST, 32'h0000_0000);
        rc(A_EN, 32'h0000_FFFF);
        rc(A_CF, 32'h0000_FFFF);
        rc(A_MD, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
    endtask

    task automatic t_tx_flags;
        pulse(E_IN);
        check(32'(irq), 32'h0000_0001);
        rc(A_ST, 32'h0000_FFFE);
        rc(A_ST, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
        pulse(E_OUT);
        rc(A_ST, 32'h0000_0000);
        pulse(E_CI);
        rc(A_ST, 32'h0000_0001);
        pulse(E_CO);
        rc(A_ST, 32'h0000_0001);
    endtask

    task automatic t_host;
        wr(A_MD, 32'h0000_0001);
        check(32'(host_mode), 32'h0000_0001);
        pulse(E_OUT);
        rc(A_ST, 32'h0000_FFFE);
        pulse(E_IN);
        rc(A_ST, 32'h0000_0000);
        wr(A_MD, 32'h0000_0000);
    endtask

    task automatic t_unconfig;
        wr(A_CF, 32'h0000_00F1);
        pulse(E_IN);
        pulse(E_CI);
        rc(A_ST, 32'h0000_00F1);
        wr(A_CF, 32'h0000_FFFF);
    endtask

    task automatic t_mask;
        wr(A_EN, 32'h0000_0000);
        pulse(E_CO);
        check(32'(irq), 32'h0000_0000);
        wr(A_EN, 32'h0000_0001);
        check(32'(irq), 32'h0000_0001);
        rc(A_ST, 32'h0000_0001);
        wr(A_EN, 32'h0000_FFFF);
    endtask

    // the event meets the clearing edge and must survive it; a write to the
    // read-only word must not clear anything
    task automatic t_race;
        rc(A_ST, 32'h0000_0000, OK, E_15);
        rc(A_ST, 32'h0000_8000);
        pulse(E_CI);
        wr(A_ST, 32'h0000_FFFF);
        rc(A_ST, 32'h0000_0001);
    endtask

    task automatic t_unmapped;
        wr(A_BAD, 32'h0000_FFFF, ERR);
        rc(A_BAD, 32'h0000_0000, ERR);
        rc(A_EN, 32'h0000_FFFF);
    endtask

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_tx_flags();
        t_host();
        t_unconfig();
        t_mask();
        t_race();
        t_unmapped();
        finish_test();
    end

    // the whole sequence needs about 120 cycles, so this is ample margin
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
